// ==== rtl/cpab_pkg.sv ====
// Package for the extended area bus configuration register block
package cpab_pkg;
  localparam logic [11:0] CPAB_CTRL_OFFS = 12'h000;
  localparam int CPAB_REG_W = 8;
  localparam logic [7:0] CPAB_CTRL_RST = 8'h32;
  localparam int CPAB_BIT_BUS8 = 5;
  localparam int CPAB_BIT_ST3 = 4;
  localparam int CPAB_BIT_FULLA = 3;
  localparam int CPAB_BIT_CLKSYS = 2;
  localparam int CPAB_BIT_EN = 0;

  typedef enum logic [1:0] {
    CPAB_RGN_BASIC,
    CPAB_RGN_IOS,
    CPAB_RGN_256K
  } cpab_region_t;

  // Settings latched at the start of one external access
  typedef struct packed {
    logic cp_area;
    logic bus8;
    logic states3;
    logic wait_ok;
    logic data_phase;
    logic full_addr;
  } cpab_acc_cfg_t;

  // Request from the bus cycle sequencer
  typedef struct packed {
    logic start;
    logic muxed;
    cpab_region_t region;
  } cpab_acc_req_t;
endpackage

// ==== rtl/cpab_ctrl.sv ====
// Extended area bus control register with APB access and access decode
//
// Behaviour
// - The area enable bit steers accesses to the extended area when set.
// - With the area enabled, the width bit selects 16-bit (0) or 8-bit (1).
// - Non-muxed, state bit 0 gives 2 states no wait, 1 gives 3 with wait.
// - Muxed, the state bit sets a 2- or 3-state data phase the same way.
// - Full address bit sets address output for strobe, 256k and CP areas, in non-muxed mode only.
// - Clock select bit picks medium clock (0) or system clock (1).
// - The clock changes over in the bus cycle before the access.
// - Reset gives width and state bits 1, the other fields 0.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module cpab_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cpab_pkg::cpab_acc_req_t acc_req,
  input wire logic cyc_start,
  input wire logic next_ext_access,
  output cpab_pkg::cpab_acc_cfg_t acc_cfg,
  output logic clk_sys_sel,
  output logic [7:0] ctrl_value
);
  import cpab_pkg::*;

  logic [7:0] ctrl_q, ctrl_d;
  logic [31:0] rdata_q, rdata_d;
  logic rdy_q, rdy_d;
  logic err_q, err_d;
  cpab_acc_cfg_t cfg_q, cfg_d;
  logic clk_q, clk_d;
  logic setup, hit, wr_done;

  function automatic logic addr_hit(input logic [11:0] a);
    return a == CPAB_CTRL_OFFS;
  endfunction

  assign setup = psel && !penable;
  assign hit = addr_hit(paddr);
  assign wr_done = psel && penable && rdy_q && pwrite && hit;

  // Register bus: zero-wait slave, answer in the access phase
  always_comb begin
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    rdy_d = 1'b0;
    err_d = 1'b0;
    if (setup) begin
      rdy_d = 1'b1;
      err_d = !hit;
      rdata_d = '0;
      if (hit && !pwrite) begin
        rdata_d[CPAB_REG_W-1:0] = ctrl_q;
      end
    end
    if (wr_done && pstrb[0]) begin
      ctrl_d = pwdata[CPAB_REG_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CPAB_CTRL_RST;
      rdata_q <= '0;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // Access decode, latched at access start from the stored value
  always_comb begin
    cfg_d = cfg_q;
    clk_d = clk_q;
    if (acc_req.start) begin
      cfg_d.cp_area = ctrl_q[CPAB_BIT_EN];
      cfg_d.bus8 = ctrl_q[CPAB_BIT_EN] && ctrl_q[CPAB_BIT_BUS8];
      cfg_d.states3 = ctrl_q[CPAB_BIT_EN] && ctrl_q[CPAB_BIT_ST3];
      cfg_d.wait_ok = ctrl_q[CPAB_BIT_EN] && ctrl_q[CPAB_BIT_ST3];
      // Muxed mode: state count applies to the data phase
      cfg_d.data_phase = acc_req.muxed;
      // Full address not honoured in muxed mode
      cfg_d.full_addr = ctrl_q[CPAB_BIT_FULLA] && !acc_req.muxed &&
        (ctrl_q[CPAB_BIT_EN] || acc_req.region != CPAB_RGN_BASIC);
    end
    // Clock changes in the cycle before the extended access
    if (cyc_start && next_ext_access) begin
      clk_d = ctrl_q[CPAB_BIT_CLKSYS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      clk_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      clk_q <= clk_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = rdy_q;
  assign pslverr = err_q;
  assign acc_cfg = cfg_q;
  assign clk_sys_sel = clk_q;
  assign ctrl_value = ctrl_q;

  // Checks
  logic wrote_q, wrote_d;

  always_comb begin
    wrote_d = wrote_q;
    if (wr_done) begin
      wrote_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrote_q <= 1'b0;
    end else begin
      wrote_q <= wrote_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Register bus phases
  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_wr;
    wr_done && pstrb[0];
  endsequence

  sequence s_rd_hit;
    psel && !penable && hit && !pwrite;
  endsequence

  // Access side events
  sequence s_start_en;
    acc_req.start && ctrl_q[CPAB_BIT_EN];
  endsequence

  sequence s_start_off;
    acc_req.start && !ctrl_q[CPAB_BIT_EN];
  endsequence

  sequence s_ext_prep;
    cyc_start && next_ext_access;
  endsequence

  // Register storage and readback
  AST_RESET_VALUE: assert property (
    !wrote_q
    |-> ctrl_q == CPAB_CTRL_RST)
    else $error("control register left reset value without a write");

  AST_WRITE_STORES: assert property (
    s_wr
    |=> ctrl_q == $past(pwdata[CPAB_REG_W-1:0]))
    else $error("written value not stored");

  AST_CTRL_HOLD: assert property (
    !(wr_done && pstrb[0])
    |=> $stable(ctrl_q))
    else $error("control register changed without a write");

  AST_READBACK: assert property (
    s_rd_hit ##1 penable
    |-> prdata[CPAB_REG_W-1:0] == ctrl_q && pready)
    else $error("read data does not match register");

  // Bus answer timing and refusals
  AST_PREADY_AFTER_SETUP: assert property (
    s_setup
    |=> pready)
    else $error("no ready in the access phase");

  AST_PREADY_PULSE: assert property (
    pready
    |=> !pready)
    else $error("ready held longer than one cycle");

  AST_PREADY_CAUSE: assert property (
    pready
    |-> $past(setup))
    else $error("ready without a preceding setup cycle");

  AST_SLVERR_UNMAPPED: assert property (
    s_setup
    |=> pslverr != $past(hit))
    else $error("error response does not follow address decode");

  AST_SLVERR_WITH_READY: assert property (
    pslverr
    |-> pready)
    else $error("error response outside the access phase");

  AST_RDATA_UPPER_ZERO: assert property (
    pready
    |-> (prdata >> CPAB_REG_W) == '0)
    else $error("read data upper bytes not zero");

  AST_UNMAPPED_READ_ZERO: assert property (
    s_setup and !hit
    |=> prdata == '0)
    else $error("unmapped read returned data");

  // Per-access settings
  AST_TARGET: assert property (
    acc_req.start
    |=> acc_cfg.cp_area == $past(ctrl_q[CPAB_BIT_EN]))
    else $error("access target not taken from enable bit");

  AST_DISABLED_ZERO: assert property (
    s_start_off
    |=> !acc_cfg.cp_area && !acc_cfg.bus8 && !acc_cfg.states3)
    else $error("area settings applied with area disabled");

  AST_WIDTH: assert property (
    s_start_en
    |=> acc_cfg.bus8 == $past(ctrl_q[CPAB_BIT_BUS8]))
    else $error("bus width wrong for extended area");

  AST_STATES_NORMAL: assert property (
    s_start_en and !acc_req.muxed
    |=> acc_cfg.states3 == acc_cfg.wait_ok && !acc_cfg.data_phase
    && acc_cfg.states3 == $past(ctrl_q[CPAB_BIT_ST3]))
    else $error("state count wrong in normal extension");

  AST_STATES_MUX: assert property (
    s_start_en and acc_req.muxed
    |=> acc_cfg.data_phase
    && acc_cfg.states3 == $past(ctrl_q[CPAB_BIT_ST3]))
    else $error("data phase state count wrong in muxed mode");

  AST_WAIT_FOLLOWS: assert property (
    acc_req.start
    |=> acc_cfg.wait_ok == acc_cfg.states3)
    else $error("wait insertion does not follow state count");

  AST_DATA_PHASE: assert property (
    acc_req.start
    |=> acc_cfg.data_phase == $past(acc_req.muxed))
    else $error("data phase flag does not follow mode");

  AST_FULLADDR: assert property (
    acc_req.start && acc_req.region == CPAB_RGN_IOS && !acc_req.muxed
    |=> acc_cfg.full_addr == $past(ctrl_q[CPAB_BIT_FULLA]))
    else $error("full address output not following its bit");

  AST_FULLADDR_256K: assert property (
    acc_req.start && acc_req.region == CPAB_RGN_256K && !acc_req.muxed
    |=> acc_cfg.full_addr == $past(ctrl_q[CPAB_BIT_FULLA]))
    else $error("full address wrong for the 256k area");

  AST_FULLADDR_BASIC: assert property (
    s_start_off and acc_req.region == CPAB_RGN_BASIC
    |=> !acc_cfg.full_addr)
    else $error("full address given to the ordinary space");

  AST_FULLADDR_MUX: assert property (
    acc_req.start && acc_req.muxed
    |=> !acc_cfg.full_addr)
    else $error("full address given in muxed mode");

  AST_CFG_HOLD: assert property (
    !acc_req.start
    |=> $stable(acc_cfg))
    else $error("access settings changed without a new access");

  // Operating clock changeover
  AST_CLK_PRIOR: assert property (
    s_ext_prep
    |=> clk_sys_sel == $past(ctrl_q[CPAB_BIT_CLKSYS]))
    else $error("clock not switched in preceding cycle");

  AST_CLK_HOLD: assert property (
    !(cyc_start && next_ext_access)
    |=> $stable(clk_sys_sel))
    else $error("clock changed outside the preceding cycle");
endmodule

// ==== sim/cpab_seq_model.sv ====
// Bus cycle sequencer model driving the access request side
`timescale 1ns/1ps
module cpab_seq_model (
  input wire logic pclk,
  input wire logic go,
  input wire logic muxed,
  input wire cpab_pkg::cpab_region_t region,
  output cpab_pkg::cpab_acc_req_t acc_req,
  output logic cyc_start,
  output logic next_ext_access
);
  import cpab_pkg::*;
  // Announces the access in the same cycle as its start request
  always @(posedge pclk) begin
    acc_req <= '{go, muxed, region};
    cyc_start <= go;
    next_ext_access <= go;
  end
endmodule

// ==== sim/cp_area_bus_config_reg_tb_top.sv ====
// Testbench for the extended area bus control register
`timescale 1ns/1ps
module cp_area_bus_config_reg_tb_top;
  import cpab_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, clk_sys_sel, go = 0, muxed = 0;
  cpab_region_t region = CPAB_RGN_BASIC;
  cpab_acc_req_t acc_req;
  logic cyc_start, next_ext_access;
  cpab_acc_cfg_t acc_cfg;
  logic [7:0] ctrl_value;
  int fails = 0, samples_checked = 0;
  cpab_ctrl i_cpab_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_req(acc_req), .cyc_start(cyc_start),
    .next_ext_access(next_ext_access), .acc_cfg(acc_cfg),
    .clk_sys_sel(clk_sys_sel), .ctrl_value(ctrl_value));
  cpab_seq_model i_cpab_seq_model (.pclk(pclk), .go(go), .muxed(muxed),
    .region(region), .acc_req(acc_req), .cyc_start(cyc_start),
    .next_ext_access(next_ext_access));
  initial begin
    forever #10 pclk = ~pclk;
  end
  task automatic complete_run;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic acc(input logic m, input cpab_region_t r,
                     input logic [5:0] e);
    @(posedge pclk);
    go <= 1;
    muxed <= m;
    region <= r;
    @(posedge pclk);
    go <= 0;
    @(posedge pclk);
    @(posedge pclk);
    chk({26'h0, acc_cfg}, {26'h0, e});
  endtask
  initial begin
    repeat (2000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, CPAB_CTRL_OFFS, 8'h00);
    chk(rd, 32'h32);
    apb(1, CPAB_CTRL_OFFS, 8'h33);
    apb(0, CPAB_CTRL_OFFS, 8'h00);
    chk(rd, 32'h33);
    apb(0, 12'h004, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1, CPAB_CTRL_OFFS, 8'h33);
    acc(0, CPAB_RGN_BASIC, 6'h3C);
    chk({31'h0, clk_sys_sel}, 32'h0);
    apb(1, CPAB_CTRL_OFFS, 8'h0F);
    acc(0, CPAB_RGN_BASIC, 6'h21);
    chk({31'h0, clk_sys_sel}, 32'h1);
    apb(1, CPAB_CTRL_OFFS, 8'h17);
    acc(1, CPAB_RGN_IOS, 6'h2E);
    apb(1, CPAB_CTRL_OFFS, 8'h0A);
    acc(0, CPAB_RGN_IOS, 6'h01);
    chk({31'h0, clk_sys_sel}, 32'h0);
    complete_run();
  end
endmodule
